/* hw/drpg_strobe.sv */
`timescale 1ns/10ps
`include "drpg_map.svh"
// Function
// - Idle drive bit 1 holds strobe high; 0 (reset) leaves it floating.
// - One low pulse per completed conversion.
// - Pulse made from master clock with fixed, repeatable width.
// - Low time is half a digital sample clock period.
// - Pulses repeat once per output rate period.
// - Strobe never waits for a host read; it always self-clears.
// - Serial port activity has no effect on strobe timing.
// - Reference select 1 disables internal reference, uses external one.
// - Reference select 0 enables internal reference onto reference pin.
// - Prescale codes 00..11 divide master clock by 1, 2, 4, 8.
// - Digital sample clock is the analog clock divided by four.
// - Output rate clock is sample clock divided by oversampling ratio.
module drpg_strobe
  import drpg_pkg::*;
#(
  parameter int RATIO_MAX = `DRPG_RATIO_MAX
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [1:0] prescale_sel,
  input wire logic [$clog2(RATIO_MAX+1)-1:0] oversampling_ratio,
  input wire logic idle_drive_select,
  input wire logic external_reference_select,
  output logic conversion_done_strobe_n_o,
  output logic conversion_done_strobe_n_oe,
  output logic internal_reference_enable,
  output logic reference_pos_pin_switch,
  output logic output_rate_clock,
  output logic digital_sample_clock
);
  localparam int CW = $clog2(RATIO_MAX + 1);

  // A limit below the smallest legal ratio, or one too large for the counters, cannot be served.
  if (RATIO_MAX < `DRPG_RATIO_MIN || RATIO_MAX > 65536) begin : g_ratio_max_check
    $error("RATIO_MAX out of range");
  end

  logic tick, half_tick;
  logic [CW-1:0] cnt_q, cnt_d;
  drpg_state_t state_q, state_d;
  logic strobe_q, strobe_d, oe_q, oe_d, iref_q, iref_d, sw_q, sw_d;
  logic rate_q, rate_d, dclk_q, dclk_d;

  // The serial port is not an input here, so it cannot disturb timing.
  drpg_tick_div u_div (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .prescale_sel(prescale_sel),
    .tick(tick),
    .half_tick(half_tick)
  );

  always_comb begin
    cnt_d = cnt_q;
    state_d = state_q;
    rate_d = 1'b0;
    dclk_d = dclk_q;
    if (tick) begin
      dclk_d = 1'b1;
      // A ratio below two would wrap every period; the count treats it as 1.
      if (cnt_q + CW'(1) >= oversampling_ratio) begin
        cnt_d = '0;
        state_d = DRPG_PULSE;
        rate_d = 1'b1;
      end else begin
        cnt_d = cnt_q + CW'(1);
      end
    end
    if (half_tick) begin
      dclk_d = 1'b0;
      state_d = DRPG_IDLE;
    end
    strobe_d = (state_d == DRPG_IDLE);
    oe_d = (state_d == DRPG_PULSE) || idle_drive_select;
    iref_d = !external_reference_select;
    sw_d = !external_reference_select;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      state_q <= DRPG_IDLE;
      strobe_q <= 1'b1;
      oe_q <= `DRPG_IDLE_DRIVE_RESET;
      iref_q <= !`DRPG_EXT_REF_RESET;
      sw_q <= !`DRPG_EXT_REF_RESET;
      rate_q <= 1'b0;
      dclk_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      state_q <= state_d;
      strobe_q <= strobe_d;
      oe_q <= oe_d;
      iref_q <= iref_d;
      sw_q <= sw_d;
      rate_q <= rate_d;
      dclk_q <= dclk_d;
    end
  end

  assign conversion_done_strobe_n_o = strobe_q;
  assign conversion_done_strobe_n_oe = oe_q;
  assign internal_reference_enable = iref_q;
  assign reference_pos_pin_switch = sw_q;
  assign output_rate_clock = rate_q;
  assign digital_sample_clock = dclk_q;

  // Core clock cycles in one digital sample clock period for a prescale code.
  function automatic int sample_period(input logic [1:0] sel);
    return `DRPG_ANALOG_PER_SAMPLE << sel;
  endfunction : sample_period

  // Ratios below two wrap the count on every sample period.
  function automatic int ratio_eff(input logic [CW-1:0] ratio);
    return (ratio < CW'(2)) ? 1 : int'(ratio);
  endfunction : ratio_eff

  // Helper state for the checks below. It measures how long the strobe stays low and how far apart
  // the rate ticks are, and notes any change of the timing inputs, since an interval in which the
  // prescale or the ratio moved has no fixed length.
  localparam int GW = CW + 5;

  logic [4:0] low_len_q, low_len_d;
  logic [GW-1:0] gap_q, gap_d;
  logic gap_valid_q, gap_valid_d;
  logic cfg_moved_q, cfg_moved_d;
  logic cfg_changed;
  logic [1:0] pre_prev_q, pre_prev_d;
  logic [CW-1:0] ratio_prev_q, ratio_prev_d;

  always_comb begin
    cfg_changed = (prescale_sel != pre_prev_q) || (oversampling_ratio != ratio_prev_q);
    pre_prev_d = prescale_sel;
    ratio_prev_d = oversampling_ratio;
    low_len_d = conversion_done_strobe_n_o ? 5'h00 : low_len_q + 5'h01;
    gap_d = output_rate_clock ? GW'(1) : gap_q + GW'(1);
    gap_valid_d = gap_valid_q || output_rate_clock;
    cfg_moved_d = (output_rate_clock ? 1'b0 : cfg_moved_q) || cfg_changed;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_len_q <= 5'h00;
      gap_q <= '0;
      gap_valid_q <= 1'b0;
      cfg_moved_q <= 1'b0;
      pre_prev_q <= `DRPG_PRE_RESET;
      ratio_prev_q <= '0;
    end else begin
      low_len_q <= low_len_d;
      gap_q <= gap_d;
      gap_valid_q <= gap_valid_d;
      cfg_moved_q <= cfg_moved_d;
      pre_prev_q <= pre_prev_d;
      ratio_prev_q <= ratio_prev_d;
    end
  end

  sequence low_start_s;
    $fell(conversion_done_strobe_n_o);
  endsequence

  // A pulse ends when the strobe returns high.
  sequence pulse_end_s;
    $rose(conversion_done_strobe_n_o);
  endsequence

  strobe_returns_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    low_start_s |-> ##[1:16] conversion_done_strobe_n_o)
    else $error("strobe stayed low too long");
  strobe_low_drive_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !conversion_done_strobe_n_o |-> conversion_done_strobe_n_oe)
    else $error("low strobe not driven");
  // At the first edge after reset the enable still holds its reset value, so that edge is left out.
  idle_float_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ($past(rst_n) && conversion_done_strobe_n_o && $past(conversion_done_strobe_n_o)
      && $stable(idle_drive_select))
    |-> conversion_done_strobe_n_oe == idle_drive_select)
    else $error("idle drive wrong");
  pulse_rate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    output_rate_clock |-> $fell(conversion_done_strobe_n_o))
    else $error("no pulse after rate tick");
  div1_width_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (low_start_s and $stable(prescale_sel) and (prescale_sel == 2'b00))
    |-> !conversion_done_strobe_n_o ##1 !conversion_done_strobe_n_o ##1 conversion_done_strobe_n_o)
    else $error("pulse width wrong at div1");
  iref_sel_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    external_reference_select |=> !internal_reference_enable)
    else $error("internal ref not disabled");
  iref_on_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !external_reference_select |=> internal_reference_enable && reference_pos_pin_switch)
    else $error("internal ref not enabled");
  count_wrap_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    output_rate_clock |-> cnt_q == '0)
    else $error("rate tick without wrap");
  pulse_width_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (pulse_end_s and (!cfg_moved_q && !cfg_changed)) |-> low_len_q == sample_period(prescale_sel) / 2)
    else $error("pulse width is not half a sample period");
  rate_spacing_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (output_rate_clock && gap_valid_q && !cfg_moved_q && !cfg_changed)
    |-> gap_q == ratio_eff(oversampling_ratio) * sample_period(prescale_sel))
    else $error("rate ticks not one output period apart");
  rate_single_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    output_rate_clock |=> !output_rate_clock)
    else $error("rate tick longer than one cycle");
  pulse_in_sample_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !conversion_done_strobe_n_o |-> digital_sample_clock)
    else $error("strobe low outside first half of sample period");
  pulse_end_half_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    pulse_end_s |-> $fell(digital_sample_clock))
    else $error("strobe did not end at sample clock middle");
  stray_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    low_start_s |-> output_rate_clock)
    else $error("strobe fell without a rate tick");
  ref_switch_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    external_reference_select |=> !reference_pos_pin_switch)
    else $error("reference switch closed on external reference");
endmodule : drpg_strobe

/* hw/drpg_map.svh */
`ifndef DRPG_MAP_SVH
`define DRPG_MAP_SVH

// Prescale codes.
`define DRPG_PRE_DIV1 2'b00
`define DRPG_PRE_DIV2 2'b01
`define DRPG_PRE_DIV4 2'b10
`define DRPG_PRE_DIV8 2'b11
`define DRPG_PRE_RESET 2'b00
// Analog clock periods per digital sample clock period.
`define DRPG_ANALOG_PER_SAMPLE 4
// Reset values of the configuration bits.
`define DRPG_IDLE_DRIVE_RESET 1'b0
`define DRPG_EXT_REF_RESET 1'b0
// Default oversampling ratio and its legal range.
`define DRPG_RATIO_DEFAULT 256
`define DRPG_RATIO_MIN 32
`define DRPG_RATIO_MAX 4096

`endif

/* hw/drpg_pkg.sv */
package drpg_pkg;
  typedef enum logic [1:0] {
    DRPG_DIV1,
    DRPG_DIV2,
    DRPG_DIV4,
    DRPG_DIV8
  } drpg_prescale_t;

  typedef enum logic {
    DRPG_IDLE,
    DRPG_PULSE
  } drpg_state_t;
endpackage : drpg_pkg

/* hw/drpg_tick_div.sv */
`timescale 1ns/10ps
`include "drpg_map.svh"

// Makes one tick per master-clock cycle divided by the prescale and by four:
// tick marks the start of a digital sample clock period, half_tick its middle.
module drpg_tick_div
  import drpg_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [1:0] prescale_sel,
  output logic tick,
  output logic half_tick
);
  // Largest count is 4 x 8 - 1.
  logic [4:0] cnt_q, cnt_d;
  logic [4:0] last;
  logic tick_q, tick_d, half_q, half_d;

  function automatic logic [4:0] period_last(input logic [1:0] sel);
    unique case (sel)
      `DRPG_PRE_DIV1: period_last = 5'h03;
      `DRPG_PRE_DIV2: period_last = 5'h07;
      `DRPG_PRE_DIV4: period_last = 5'h0F;
      `DRPG_PRE_DIV8: period_last = 5'h1F;
    endcase
  endfunction : period_last

  always_comb begin
    last = period_last(prescale_sel);
    cnt_d = (cnt_q >= last) ? 5'h00 : cnt_q + 5'h01;
    tick_d = (cnt_q >= last);
    half_d = (cnt_q == (last >> 1));
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 5'h00;
      tick_q <= 1'b0;
      half_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
      half_q <= half_d;
    end
  end

  assign tick = tick_q;
  assign half_tick = half_q;
endmodule : drpg_tick_div

/* dv/drpg_host_irq.sv */
`timescale 1ns/10ps
module drpg_host_irq (
  input wire logic strobe_o,
  input wire logic strobe_oe,
  output logic pin,
  output int irq_count
);
  // The line has a pull-up, so a released strobe reads high.
  assign pin = strobe_oe ? strobe_o : 1'b1;
  initial irq_count = 0;
  always @(negedge pin) irq_count <= irq_count + 1;
endmodule : drpg_host_irq

/* dv/tb_data_ready_pulse_gen.sv */
`timescale 1ns/10ps
module tb_data_ready_pulse_gen;
  import drpg_pkg::*;
  logic core_clk, rst_n, idle, ext, s_o, s_oe, iref, sw, rate, dclk, pin;
  logic [1:0] pre;
  logic [12:0] ratio;
  int irq_count, bad_count, num_checks, seed, cyc, w, k, r;
  drpg_strobe dut_u (.core_clk(core_clk), .rst_n(rst_n), .prescale_sel(pre),
    .oversampling_ratio(ratio), .idle_drive_select(idle), .external_reference_select(ext),
    .conversion_done_strobe_n_o(s_o), .conversion_done_strobe_n_oe(s_oe),
    .internal_reference_enable(iref), .reference_pos_pin_switch(sw),
    .output_rate_clock(rate), .digital_sample_clock(dclk));
  drpg_host_irq host_u (.strobe_o(s_o), .strobe_oe(s_oe), .pin(pin), .irq_count(irq_count));
  function automatic int period(input logic [1:0] p);
    return 4 << p;
  endfunction : period
  task automatic step();
    @(posedge core_clk);
    #1;
  endtask : step
  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic finish_test();
    $display("Checks %0d, errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test
  task automatic wait_rate();
    for (k = 0; k < 2000 && rate !== 1'b1; k++) step();
    if (rate !== 1'b1) begin
      bad_count++;
      $display("Error at %0t: no rate pulse", $time);
      finish_test();
    end
  endtask : wait_rate
  task automatic run_cfg(input logic [1:0] p, input int n, input logic i, input logic e);
    int c0;
    int i0;
    rst_n = 1'b0;
    pre = p;
    ratio = n[12:0];
    idle = i;
    ext = e;
    repeat (3) step();
    check(s_o === 1'b1 && s_oe === 1'b0 && iref === 1'b1 && sw === 1'b1 && dclk === 1'b0, "reset state");
    rst_n = 1'b1;
    step();
    step();
    check(iref === !e && sw === !e, "reference select");
    wait_rate();
    c0 = cyc;
    i0 = irq_count;
    // The strobe falls at the same edge that raises the rate tick.
    check(s_o === 1'b0 && dclk === 1'b1, "pulse start");
    for (w = 0; w < 40 && s_o === 1'b0 && s_oe === 1'b1; w++) step();
    check(w == period(p) / 2, "pulse width");
    check(s_o === 1'b1 && s_oe === i && pin === 1'b1 && dclk === 1'b0, "idle level");
    wait_rate();
    check(irq_count == i0 + 1, "one pulse");
    check(cyc - c0 == n * period(p), "pulse spacing");
  endtask : run_cfg
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) cyc <= cyc + 1;
  initial begin
    seed = 32'h6b2f_cd2c;
    cyc = 0;
    bad_count = 0;
    num_checks = 0;
    rst_n = 1'b0;
    pre = 2'b00;
    ratio = 13'h0002;
    idle = 1'b0;
    ext = 1'b0;
    repeat (3) step();
    run_cfg(2'b00, 2, 1'b0, 1'b0);
    run_cfg(2'b11, 5, 1'b1, 1'b1);
    run_cfg(2'b01, 1, 1'b1, 1'b0);
    for (int j = 0; j < 8; j++) begin
      r = $random(seed);
      run_cfg(j[1:0], 2 + ((r >>> 4) & 7), r[0], r[1]);
    end
    finish_test();
  end
endmodule : tb_data_ready_pulse_gen
